// File: cmh_dev.sv
// Behavioural model of the device micro port that the host drives
`timescale 1ns/1ns
module cmh_dev (
    input wire logic port_clk,
    input wire logic arst_n,
    input wire logic mode_sel,
    input wire logic [2:0] slow,
    input wire cmh_pkg::cmh_pins_t pins,
    output logic [cmh_pkg::CMH_DW-1:0] data_in,
    output logic xfer_ack_n
);
    import cmh_pkg::*;
    logic [7:0] mem_r [8];
    logic [7:0] last_r;
    logic [3:0] cnt_r;
    logic rd;
    logic act;
    logic [3:0] lat;
    // Shared strobe is the read strobe in mode 0, the data strobe in mode 1
    assign rd = mode_sel ? pins.rw_wr : !pins.strobe_n;
    assign act = !pins.cs_n && (!pins.strobe_n || (!mode_sel && !pins.rw_wr));
    // Edges from N to release; slow stretches it to test a sluggish device
    assign lat = 4'(slow) + (((rd && pins.addr == 3'h0) || (mode_sel && !rd)) ? 4'h3 : 4'h2);
    // Mode 0 ready falls at once; mode 1 acknowledge only moves on edges
    assign xfer_ack_n = mode_sel ? !(cnt_r > lat) : (!act || cnt_r > lat);
    // Released bus shows the inverse of its last value, so no stale byte passes
    assign data_in = (act && rd) ? mem_r[pins.addr] : ~last_r;
    // Deselect sampled on an edge ends the access and frees the port at once
    always_ff @(posedge port_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 4'h0;
            last_r <= 8'h00;
        end else begin
            cnt_r <= act ? cnt_r + {3'h0, cnt_r != 4'hf} : 4'h0;
            last_r <= data_in;
        end
    end
    // Register file; every selected write edge captures the byte
    always_ff @(posedge port_clk) begin
        if (act && !rd) mem_r[pins.addr] <= pins.dout;
    end
endmodule

// File: cmh_host.sv
// Host controller driving the clocked micro port in either handshake mode
`timescale 1ns/1ns
module cmh_host (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic mode_sel,
    input wire logic req_valid,
    output logic req_ready,
    input wire cmh_pkg::cmh_req_t req,
    output cmh_pkg::cmh_rsp_t rsp,
    output logic port_clk,
    output cmh_pkg::cmh_pins_t pins,
    input wire logic [cmh_pkg::CMH_DW-1:0] data_in,
    input wire logic xfer_ack_n
);
    import cmh_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_WAIT = 3'b010,
        ST_END = 3'b011,
        ST_GAP = 3'b100
    } cmh_state_t;

    cmh_state_t st_r;
    cmh_pins_t drive_r;
    logic ack_s;
    logic ack_low_r;
    logic [CMH_DW-1:0] din_s;
    logic [7:0] tmo_r;
    logic [1:0] gap_r;
    logic clk_div_r;
    logic mode_r;
    logic take;
    logic finish;
    logic tmo_hit;
    logic sel_seen;

    // Completion seen: ready went low then back high (mode 0), or ack low (mode 1)
    function automatic logic ack_done(input logic m, input logic a, input logic seen_low);
        ack_done = m ? !a : (seen_low && a);
    endfunction

    // Strobe pair {strobe_n, rw_wr} for an access in the given mode.
    // Mode 1 pulls the data strobe and shows direction on read/write;
    // mode 0 pulls the read strobe for a read, the write strobe for a write.
    function automatic logic [1:0] strobe_pair(input logic m, input logic wr);
        if (m) begin
            strobe_pair = {1'b0, !wr};
        end else begin
            strobe_pair = {wr, !wr};
        end
    endfunction

    // Ready/acknowledge is a pin from the device; three-flop filtered.
    // In mode 0 it falls with no clock at all, so it is truly asynchronous.
    cmh_sync u_ack_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d_in(xfer_ack_n),
        .q_out(ack_s)
    );

    // Read data bus, one filter per bit. Same latency as the acknowledge
    // path, and the device drives the byte well before it acknowledges,
    // so no bit can still be in flight when the byte is captured.
    genvar gi;
    generate
        for (gi = 0; gi < CMH_DW; gi++) begin : g_din
            cmh_sync u_din_sync (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .d_in(data_in[gi]),
                .q_out(din_s[gi])
            );
        end
    endgenerate

    // Device port clock at half our rate, so pins settle between its rising edges
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clk_div_r <= 1'b0;
        end else begin
            clk_div_r <= ~clk_div_r;
        end
    end
    assign port_clk = clk_div_r;

    // Handshake events of this cycle
    assign take = (st_r == ST_IDLE) && req_valid && req_ready;
    assign tmo_hit = (st_r == ST_WAIT) && (tmo_r == 8'h00);
    assign finish = (st_r == ST_WAIT) && (ack_done(mode_r, ack_s, ack_low_r) || tmo_hit);
    // Selection as the device really sees it, not as we intend it
    assign sel_seen = !pins.cs_n;

    // Mode is latched per access so a pin change mid-access cannot split it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= 1'b0;
        end else if (take) begin
            mode_r <= mode_sel;
        end
    end

    // Request side: ready only while idle, dropped on the edge that takes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (st_r == ST_IDLE) && !take;
        end
    end

    // Access sequencer; the setup and end steps wait for the pins to reach the device
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_IDLE;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    if (take) begin
                        st_r <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Strobes only once chip select is out, for address setup
                    if (sel_seen) begin
                        st_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (finish) begin
                        st_r <= ST_END;
                    end
                end
                ST_END: begin
                    // Deselect must be on the pins before the access counts done
                    if (!sel_seen) begin
                        st_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // Mode 1 also waits for the acknowledge to be forced high
                    if (gap_r == 2'h0 && (mode_r ? ack_s : 1'b1)) begin
                        st_r <= ST_IDLE;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Acknowledge watchdog; a device in the wrong mode must not hang us
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tmo_r <= 8'h00;
        end else if (st_r == ST_SETUP) begin
            tmo_r <= CMH_ACK_TIMEOUT_CYC;
        end else if (st_r == ST_WAIT && tmo_r != 8'h00) begin
            tmo_r <= tmo_r - 8'h01;
        end
    end

    // Mode 0 ready has to be seen low before its return high means done
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_low_r <= 1'b0;
        end else if (st_r == ST_SETUP) begin
            ack_low_r <= 1'b0;
        end else if (st_r == ST_WAIT && !ack_s) begin
            ack_low_r <= 1'b1;
        end
    end

    // Idle gap after deselect; holds at zero while mode 1 waits for ack
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gap_r <= 2'h0;
        end else if (st_r == ST_END) begin
            gap_r <= CMH_GAP_CYC;
        end else if (st_r == ST_GAP && gap_r != 2'h0) begin
            gap_r <= gap_r - 2'h1;
        end
    end

    // Pin levels the sequencer wants; they reach the pins one stage later
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drive_r <= '{cs_n: 1'b1, strobe_n: 1'b1, rw_wr: 1'b1,
                         addr: 3'h0, dout: 8'h00, doe: 1'b0};
        end else if (take) begin
            drive_r.addr <= req.addr;
            drive_r.dout <= req.wdata;
            drive_r.doe <= req.write;
            drive_r.cs_n <= 1'b0;
        end else if (st_r == ST_SETUP && sel_seen) begin
            // One word per access; strobes are never held across accesses
            {drive_r.strobe_n, drive_r.rw_wr} <= strobe_pair(mode_r, drive_r.doe);
        end else if (finish) begin
            drive_r.cs_n <= 1'b1;
            drive_r.strobe_n <= 1'b1;
            drive_r.rw_wr <= 1'b1;
        end else if (st_r == ST_END && !sel_seen) begin
            // Data stays driven until deselect is out, for hold time
            drive_r.doe <= 1'b0;
        end
    end

    // Pins move only on the edge where the port clock falls, so they are
    // half a port period clear of the device's rising sampling edge. The
    // cost is up to one extra system cycle per step.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pins <= '{cs_n: 1'b1, strobe_n: 1'b1, rw_wr: 1'b1,
                      addr: 3'h0, dout: 8'h00, doe: 1'b0};
        end else if (clk_div_r) begin
            pins <= drive_r;
        end
    end

    // Answer to the requester: one-cycle flags, read byte held until next
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rsp <= '0;
        end else begin
            rsp.done <= (st_r == ST_END) && !sel_seen;
            rsp.timeout <= tmo_hit;
            if (finish) begin
                rsp.rdata <= din_s;
            end
        end
    end
endmodule

// File: cmh_host_chk.sv
// Checker on the host port controller pins and request handshake
`timescale 1ns/1ns
module cmh_host_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire cmh_pkg::cmh_rsp_t rsp,
    input wire cmh_pkg::cmh_pins_t pins
);
    import cmh_pkg::*;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Strobes only inside a selected access; the address holds while selected
    strobe_in_cs_a: assert property ((!pins.strobe_n || !pins.rw_wr) |-> !pins.cs_n)
        else $error("strobe while deselected");
    addr_steady_a: assert property ((!pins.cs_n && !$past(pins.cs_n)) |-> $stable(pins.addr))
        else $error("address moved in access");
    cs_end_clean_a: assert property ($rose(pins.cs_n) |-> (pins.strobe_n && pins.rw_wr))
        else $error("strobe left after deselect");
    // Completion only once the device is deselected, and only for one cycle
    done_idle_a: assert property (rsp.done |-> pins.cs_n)
        else $error("done while selected");
    done_pulse_a: assert property (rsp.done |=> !rsp.done)
        else $error("done longer than a cycle");
    // One access at a time, with a gap so the next starts no earlier than allowed
    take_once_a: assert property ((req_valid && req_ready) |=> !req_ready)
        else $error("ready after take");
    gap_after_a: assert property (rsp.done |=> !req_ready [*2])
        else $error("no gap after done");
    ready_idle_a: assert property (req_ready |-> pins.cs_n)
        else $error("ready while selected");
endmodule
bind cmh_host cmh_host_chk chk (.clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .rsp(rsp), .pins(pins));

// File: cmh_host_tb.sv
// Self-checking bench for the host port controller against the device model
`timescale 1ns/1ns
module cmh_host_tb;
    import cmh_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic mode_sel = 1'b0;
    logic dev_mode = 1'b0;
    logic req_valid = 1'b0;
    logic [2:0] slow = 3'h0;
    logic req_ready, port_clk, xfer_ack_n;
    logic [7:0] data_in;
    cmh_req_t req = '0;
    cmh_rsp_t rsp, got;
    cmh_pins_t pins;
    int mismatches = 0;
    int check_count = 0;
    always #5 clk_sys = ~clk_sys;
    cmh_host dut (.clk_sys(clk_sys), .arst_n(arst_n), .mode_sel(mode_sel), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp(rsp), .port_clk(port_clk), .pins(pins),
        .data_in(data_in), .xfer_ack_n(xfer_ack_n));
    cmh_dev dev (.port_clk(port_clk), .arst_n(arst_n), .mode_sel(dev_mode), .slow(slow),
        .pins(pins), .data_in(data_in), .xfer_ack_n(xfer_ack_n));
    task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] pat(input int i, input logic m);
        return 8'(i * 37 + 60) ^ {m, 7'h00};
    endfunction
    // One request; got keeps the answer, a hang shows as neither flag
    task automatic xfer(input logic m, input logic dm, input logic w, input int a);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        mode_sel = m;
        dev_mode = dm;
        req = {w, 3'(a), pat(a, m)};
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
        got = '0;
        for (n = 0; n < 400 && got.done !== 1'b1 && got.timeout !== 1'b1; n++) begin
            @(negedge clk_sys);
            got = rsp;
        end
    endtask
    // Fill every address, then read all back, internal address included
    task automatic s_rw(input logic m, input logic [2:0] s);
        slow = s;
        for (int i = 0; i < 8; i++) begin
            xfer(m, m, 1'b1, i);
            chk_val({6'h0, got.done, got.timeout}, 8'h02);
        end
        for (int i = 0; i < 8; i++) begin
            xfer(m, m, 1'b0, i);
            chk_val(got.rdata, pat(i, m));
        end
    endtask
    // Device in the other mode never completes; host gives up, then recovers after reset
    task automatic s_fault();
        xfer(1'b0, 1'b1, 1'b0, 2);
        chk_val({6'h0, got.done, got.timeout}, 8'h01);
        arst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        xfer(1'b1, 1'b1, 1'b0, 2);
        chk_val(got.rdata, pat(2, 1'b1));
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence: both modes, prompt and slow device, then the fault case
    initial begin
        repeat (5) @(negedge clk_sys);
        arst_n = 1'b1;
        s_rw(1'b0, 3'h0);
        s_rw(1'b1, 3'h0);
        s_rw(1'b0, 3'h7);
        s_rw(1'b1, 3'h5);
        s_fault();
        tally_and_finish();
    end
    // Watchdog, several times the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        tally_and_finish();
    end
endmodule

// File: cmh_pkg.sv
// Package for the clocked micro host port controller: constants, types and functional notes
// Functional notes
// - Device samples port controls, address and data only on rising clock edges.
// - Host drives 3-bit address, 8-bit data, only while chip select is low; the host keeps data driven until deselect is on the pins.
// - Mode 0: host may keep reading with write high and read strobe low.
// - Mode 0 read ends when host raises chip select and device samples it.
// - Mode 0: host may hold write strobes low to write further words.
// - Mode 0 write ends when host raises chip select and device samples it.
// - After a completed write the next write may start at edge N-star.
// - Mode 1: host may keep reading with read/write high and strobe low.
// - Mode 1 read ends when chip select high is sampled; acknowledge forced high.
// - Mode 1: host may hold read/write and strobe low to keep writing.
// - Mode 1 write ends on sampled chip select high; acknowledge forced high.
package cmh_pkg;
    localparam int CMH_AW = 3;
    localparam int CMH_DW = 8;
    // Worst-case acknowledge wait before the host gives up
    localparam int CMH_ACK_TIMEOUT_NS = 2000;
    localparam int CMH_CLK_NS = 10;
    localparam logic [7:0] CMH_ACK_TIMEOUT_CYC = 8'(CMH_ACK_TIMEOUT_NS / CMH_CLK_NS);
    // Idle cycles between chip select high and the next access (covers N-star)
    localparam logic [1:0] CMH_GAP_CYC = 2'h2;
    localparam logic [CMH_AW-1:0] CMH_ADDR_INTERNAL = 3'h0;

    typedef struct packed {
        logic cs_n;
        logic strobe_n;   // Read strobe in mode 0, data strobe in mode 1
        logic rw_wr;      // Write strobe (low) in mode 0, read/write in mode 1
        logic [CMH_AW-1:0] addr;
        logic [CMH_DW-1:0] dout;
        logic doe;
    } cmh_pins_t;

    typedef struct packed {
        logic write;
        logic [CMH_AW-1:0] addr;
        logic [CMH_DW-1:0] wdata;
    } cmh_req_t;

    typedef struct packed {
        logic done;
        logic timeout;
        logic [CMH_DW-1:0] rdata;
    } cmh_rsp_t;
endpackage

// File: cmh_sync.sv
// Three-stage input synchroniser with second/third agreement filter
`timescale 1ns/1ns
module cmh_sync (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic d_in,
    output logic q_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // First stage feeds only the second; output moves once stages two and three agree
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            q_out <= 1'b1;
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_out <= s3_r;
            end
        end
    end
endmodule
